// [pmscc_charge_ctrl.v]
`timescale 1ns/1ps
`include "pmscc_defines.vh"
module pmscc_charge_ctrl #(
	parameter [`PMSCC_CNT_W-1:0] WAIT_CYC = `PMSCC_WAIT_CYC,
	parameter [`PMSCC_CNT_W-1:0] DECODE_CYC = `PMSCC_DECODE_CYC,
	parameter [`PMSCC_CNT_W-1:0] OVP_CYC = `PMSCC_OVP_CYC,
	parameter [`PMSCC_CNT_W-1:0] DEGLITCH_CYC = `PMSCC_DEGLITCH_CYC,
	parameter [`PMSCC_CNT_W-1:0] PULSE_MIN_CYC = `PMSCC_PULSE_MIN_CYC,
	parameter [`PMSCC_CNT_W-1:0] PULSE_MAX_CYC = `PMSCC_PULSE_MAX_CYC
) (
	// clock and reset
	input wire i_sys_clk,
	input wire i_reset,
	// enable/programming line, high disables
	input wire i_enable_line,
	// analog comparator results
	input wire i_above_undervoltage_lockout,
	input wire i_above_ovp,
	input wire i_above_battery_80mv,
	input wire i_below_recharge_threshold,
	input wire i_above_precharge_exit_threshold,
	input wire i_at_battery_regulation_voltage,
	input wire i_below_done_threshold,
	input wire i_resistor_below_default_limit,
	// power stage controls
	output reg o_charge_switch_on,
	output reg o_ldo_on,
	output reg o_precharge_current,
	output reg o_limit_to_resistor,
	output reg o_limit_low,
	output reg o_voltage_regulation,
	output reg o_production_test_mode,
	output reg o_thermal_regulation_on,
	output reg o_quiescent_reduced,
	output reg [`PMSCC_MODE_W-1:0] o_mode,
	output reg [`PMSCC_PH_W-1:0] o_phase,
	// open-drain status pins, enable high pulls low
	output wire o_charge_done_n,
	output reg o_charge_done_n_oe,
	output wire o_source_valid_n,
	output reg o_source_valid_n_oe
);
	localparam ST_OFF = 5'h01;
	localparam ST_WAIT = 5'h02;
	localparam ST_COUNT = 5'h04;
	localparam ST_RUN = 5'h08;
	localparam ST_DIS = 5'h10;

	reg [4:0] state;
	reg [4:0] next_state;
	reg [`PMSCC_PULSE_W-1:0] pulses;
	reg [`PMSCC_PULSE_W-1:0] next_pulses;
	reg [`PMSCC_MODE_W-1:0] next_mode;
	reg [`PMSCC_CNT_W-1:0] wait_cnt;
	reg done_latched;
	wire enabled_dg;
	wire ovp_dg;
	wire ovp_trip;
	wire [`PMSCC_CNT_W-1:0] held;
	wire held_level;
	wire source_valid;
	wire fell;
	wire valid_width;

	assign o_charge_done_n = 1'b0;
	assign o_source_valid_n = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// filters and time base
	// filters the enabling low level, so a line held high at release never looks enabled
	pmscc_deglitch #(.LIMIT(DEGLITCH_CYC)) u_line_dg (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_level(!i_enable_line),
		.o_level(enabled_dg)
	);
	pmscc_deglitch #(.LIMIT(OVP_CYC)) u_ovp_dg (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_level(i_above_ovp),
		.o_level(ovp_dg)
	);
	pmscc_timer u_time (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_level(i_enable_line),
		.o_count(held),
		.o_level(held_level)
	);

	// raw line compared against timer level: falling edge marks end of a high pulse
	assign fell = held_level && !i_enable_line;
	assign valid_width = (held >= PULSE_MIN_CYC - 22'h000001)
		&& (held <= PULSE_MAX_CYC - 22'h000001);
	assign source_valid = i_above_undervoltage_lockout && !i_above_ovp && i_above_battery_80mv;
	// trip waits for the deglitch, release follows the raw comparator at once
	assign ovp_trip = ovp_dg && i_above_ovp;

	////////////////////////////////////////////////////////////////////////
	// enable line sequencing
	always @* begin
		next_state = state;
		next_pulses = pulses;
		next_mode = o_mode;
		case (state)
			ST_OFF: begin
				if (enabled_dg) begin
					next_state = ST_WAIT;
					next_pulses = {`PMSCC_PULSE_W{1'b0}};
				end
			end
			ST_WAIT: begin
				if (fell && valid_width) begin
					next_pulses = pulses + 3'h1;
					next_state = ST_COUNT;
				end else if (wait_cnt >= WAIT_CYC - 22'h000001) begin
					next_mode = `PMSCC_MODE_DEFAULT;
					next_state = ST_RUN;
				end
			end
			ST_COUNT: begin
				if (fell && valid_width) begin
					next_pulses = pulses + 3'h1;
					if (next_pulses == `PMSCC_PULSE_FOUR) begin
						next_mode = `PMSCC_MODE_LOW;
						next_state = ST_RUN;
					end
				end else if (!i_enable_line && held >= DECODE_CYC - 22'h000001) begin
					next_state = ST_RUN;
					case (pulses)
						3'h0: next_mode = `PMSCC_MODE_DEFAULT;
						3'h1: next_mode = `PMSCC_MODE_RESISTOR;
						3'h2: next_mode = `PMSCC_MODE_LOW;
						3'h3: next_mode = `PMSCC_MODE_TEST;
						default: next_mode = `PMSCC_MODE_LOW;
					endcase
				end
			end
			// pulses no longer looked at here
			ST_RUN: next_state = ST_RUN;
			ST_DIS: begin
				if (enabled_dg) begin
					next_state = ST_WAIT;
					next_pulses = {`PMSCC_PULSE_W{1'b0}};
				end
			end
			default: next_state = ST_OFF;
		endcase
		// long high disables from any state, also straight after power-up
		if (state != ST_DIS && i_enable_line && held_level && held >= DECODE_CYC) begin
			next_state = ST_DIS;
		end
		if (!i_above_undervoltage_lockout) begin
			next_state = ST_OFF;
		end
	end

	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			state <= ST_OFF;
			pulses <= {`PMSCC_PULSE_W{1'b0}};
			o_mode <= `PMSCC_MODE_DEFAULT;
			wait_cnt <= {`PMSCC_CNT_W{1'b0}};
		end else begin
			state <= next_state;
			pulses <= next_pulses;
			o_mode <= next_mode;
			if (state == ST_WAIT && next_state == ST_WAIT) begin
				wait_cnt <= wait_cnt + 22'h000001;
			end else begin
				wait_cnt <= {`PMSCC_CNT_W{1'b0}};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// charge phases
	wire running;
	assign running = (state == ST_RUN) && source_valid && !ovp_trip && !i_enable_line;

	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_phase <= `PMSCC_PH_OFF;
			done_latched <= 1'b0;
		end else if (!running) begin
			o_phase <= `PMSCC_PH_OFF;
			// done state only forgotten when disabled or powered down
			if (state != ST_RUN) begin
				done_latched <= 1'b0;
			end
		end else begin
			case (o_phase)
				`PMSCC_PH_OFF: begin
					if (i_below_recharge_threshold) begin
						o_phase <= `PMSCC_PH_PRE;
					end
				end
				`PMSCC_PH_PRE: begin
					if (i_above_precharge_exit_threshold) begin
						o_phase <= `PMSCC_PH_FAST;
					end
				end
				`PMSCC_PH_FAST: begin
					if (!i_above_precharge_exit_threshold) begin
						o_phase <= `PMSCC_PH_PRE;
					end else if (i_at_battery_regulation_voltage) begin
						o_phase <= `PMSCC_PH_CV;
					end
				end
				`PMSCC_PH_CV: begin
					if (i_below_done_threshold) begin
						done_latched <= 1'b1;
					end
					if (!i_above_precharge_exit_threshold) begin
						o_phase <= `PMSCC_PH_PRE;
					end
				end
				default: o_phase <= `PMSCC_PH_OFF;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered outputs
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_charge_switch_on <= 1'b0;
			o_ldo_on <= 1'b0;
			o_precharge_current <= 1'b0;
			o_limit_to_resistor <= 1'b0;
			o_limit_low <= 1'b0;
			o_voltage_regulation <= 1'b0;
			o_production_test_mode <= 1'b0;
			o_thermal_regulation_on <= 1'b1;
			o_quiescent_reduced <= 1'b0;
			o_charge_done_n_oe <= 1'b0;
			o_source_valid_n_oe <= 1'b0;
		end else begin
			o_charge_switch_on <= running && (o_phase != `PMSCC_PH_OFF);
			o_ldo_on <= i_above_undervoltage_lockout && !ovp_trip;
			o_precharge_current <= running && o_phase == `PMSCC_PH_PRE;
			o_limit_to_resistor <= (o_mode == `PMSCC_MODE_RESISTOR)
				|| (o_mode == `PMSCC_MODE_DEFAULT && i_resistor_below_default_limit);
			o_limit_low <= o_mode == `PMSCC_MODE_LOW;
			o_voltage_regulation <= running && o_phase == `PMSCC_PH_CV;
			o_production_test_mode <= state == ST_RUN && o_mode == `PMSCC_MODE_TEST;
			o_thermal_regulation_on <= !(state == ST_RUN && o_mode == `PMSCC_MODE_TEST);
			o_quiescent_reduced <= state == ST_DIS;
			o_charge_done_n_oe <= i_above_undervoltage_lockout && running && !done_latched
				&& o_phase != `PMSCC_PH_OFF;
			o_source_valid_n_oe <= source_valid;
		end
	end
endmodule

// [pmscc_checker_assertions.sv]
`timescale 1ns/1ps
`include "pmscc_defines.vh"
module pmscc_checker #(
	parameter int OVP_CYC = 20,
	parameter int DECODE_CYC = 12000
) (
	// clock and reset
	input wire i_sys_clk,
	input wire i_reset,
	// watched inputs
	input wire i_enable_line,
	input wire i_above_undervoltage_lockout,
	input wire i_above_ovp,
	input wire i_above_battery_80mv,
	input wire i_below_recharge_threshold,
	input wire i_above_precharge_exit_threshold,
	// watched outputs
	input wire o_charge_switch_on,
	input wire o_ldo_on,
	input wire o_precharge_current,
	input wire o_voltage_regulation,
	input wire o_production_test_mode,
	input wire o_thermal_regulation_on,
	input wire o_quiescent_reduced,
	input wire [`PMSCC_PH_W-1:0] o_phase,
	input wire o_charge_done_n_oe,
	input wire o_source_valid_n_oe
);
	int ovp_cnt;
	int hi_cnt;
	////////////////////////////////////////////////////////////////
	// cleared in reset so a long high line before release never counts
	always @(posedge i_sys_clk) begin
		ovp_cnt <= (i_reset || !i_above_ovp) ? 0 : ovp_cnt + 1;
		hi_cnt <= (i_reset || !i_enable_line) ? 0 : hi_cnt + 1;
	end
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_reset);
	////////////////////////////////////////////////////////////////
	a_lockout_all_off: assert property (!i_above_undervoltage_lockout [*3] |-> !o_charge_switch_on &&
		!o_charge_done_n_oe && !o_source_valid_n_oe) else $error("output active in lockout");
	a_ovp_shuts_down: assert property (ovp_cnt > OVP_CYC + 3 |->
		!o_ldo_on && !o_charge_switch_on) else $error("ldo or charge on in overvoltage");
	a_source_invalid: assert property (!i_above_battery_80mv [*3] |->
		!o_source_valid_n_oe && !o_charge_switch_on) else $error("source taken as valid");
	a_no_start_full: assert property ((o_phase == `PMSCC_PH_OFF &&
		!i_below_recharge_threshold) [*3] |=> o_phase == `PMSCC_PH_OFF)
		else $error("charging began above recharge level");
	a_stay_precharge: assert property (o_phase == `PMSCC_PH_PRE &&
		!i_above_precharge_exit_threshold ##1 !i_above_precharge_exit_threshold
		|=> o_phase != `PMSCC_PH_FAST) else $error("left precharge too early");
	a_pre_current: assert property (o_phase == `PMSCC_PH_PRE [*2] |->
		o_precharge_current) else $error("precharge without reduced current");
	a_cv_regulates: assert property (o_phase == `PMSCC_PH_CV [*2] |->
		o_voltage_regulation) else $error("cv phase without voltage loop");
	a_done_kept: assert property ((o_phase != `PMSCC_PH_OFF) [*4] ##0
		!o_charge_done_n_oe ##1 o_phase != `PMSCC_PH_OFF |-> !o_charge_done_n_oe)
		else $error("done indicator pulled low again");
	a_disable_quiet: assert property (hi_cnt > DECODE_CYC + 4 |->
		o_quiescent_reduced && !o_charge_switch_on) else $error("long high did not disable");
	a_test_no_thermal: assert property (o_production_test_mode [*2] |->
		!o_thermal_regulation_on) else $error("thermal loop on in test mode");
endmodule
bind pmscc_charge_ctrl pmscc_checker #(.OVP_CYC(OVP_CYC), .DECODE_CYC(DECODE_CYC)) u_chk (
	.i_sys_clk(i_sys_clk),
	.i_reset(i_reset),
	.i_enable_line(i_enable_line),
	.i_above_undervoltage_lockout(i_above_undervoltage_lockout),
	.i_above_ovp(i_above_ovp),
	.i_above_battery_80mv(i_above_battery_80mv),
	.i_below_recharge_threshold(i_below_recharge_threshold),
	.i_above_precharge_exit_threshold(i_above_precharge_exit_threshold),
	.o_charge_switch_on(o_charge_switch_on),
	.o_ldo_on(o_ldo_on),
	.o_precharge_current(o_precharge_current),
	.o_voltage_regulation(o_voltage_regulation),
	.o_production_test_mode(o_production_test_mode),
	.o_thermal_regulation_on(o_thermal_regulation_on),
	.o_quiescent_reduced(o_quiescent_reduced),
	.o_phase(o_phase),
	.o_charge_done_n_oe(o_charge_done_n_oe),
	.o_source_valid_n_oe(o_source_valid_n_oe)
);

// [pmscc_defines.vh]
// Functional notes
// - after enable deglitch, a 32 ms wait window accepts programming pulses
// - no pulses in the wait window starts in default input limit mode
// - line low 1.5 ms after pulses hands the count to decode
// - count 0 default, 1 resistor, 2 low limit, 3 test, 4+ low limit
// - fourth pulse selects low input limit mode at once
// - after one programming, further pulses ignored until disable or power cycle
// - line high over 1.5 ms disables the part and suspends charging
// - charging starts only below recharge threshold, source valid, line low
// - source valid needs input above battery plus 80 mV, below OVERVOLTAGE_PROTECT, above UNDERVOLTAGE_LOCKOUT
// - below precharge exit threshold stay in precharge at 20 percent current
// - above precharge exit threshold go to fast charge at selected limit
// - at regulation voltage switch to voltage regulation
// - current at done threshold releases done indicator, charging continues
// - default mode limits to resistor current when that is lower
// - precharge is 20 percent of resistor current, low limit may clamp
// - test mode disables thermal regulation, keeps thermal shutdown
// - below UNDERVOLTAGE_LOCKOUT stay down, ignore line, switch off, status outputs released
// - input above OVERVOLTAGE_PROTECT past 115 us deglitch turns LDO and charging off
// - done indicator stays released during later refresh charges
`ifndef PMSCC_DEFINES_VH
`define PMSCC_DEFINES_VH
`define PMSCC_CLK_MHZ 100
`define PMSCC_DEGLITCH_US 50
`define PMSCC_WAIT_MS 32
`define PMSCC_PULSE_MIN_US 100
`define PMSCC_PULSE_MAX_US 700
`define PMSCC_DECODE_US 1500
`define PMSCC_OVP_US 115
`define PMSCC_DEGLITCH_CYC (`PMSCC_DEGLITCH_US * `PMSCC_CLK_MHZ)
`define PMSCC_WAIT_CYC (`PMSCC_WAIT_MS * 1000 * `PMSCC_CLK_MHZ)
`define PMSCC_PULSE_MIN_CYC (`PMSCC_PULSE_MIN_US * `PMSCC_CLK_MHZ)
`define PMSCC_PULSE_MAX_CYC (`PMSCC_PULSE_MAX_US * `PMSCC_CLK_MHZ)
`define PMSCC_DECODE_CYC (`PMSCC_DECODE_US * `PMSCC_CLK_MHZ)
`define PMSCC_OVP_CYC (`PMSCC_OVP_US * `PMSCC_CLK_MHZ)
`define PMSCC_CNT_W 22
// mode encoding
`define PMSCC_MODE_W 2
`define PMSCC_MODE_DEFAULT 2'h0
`define PMSCC_MODE_RESISTOR 2'h1
`define PMSCC_MODE_LOW 2'h2
`define PMSCC_MODE_TEST 2'h3
// charge phase encoding
`define PMSCC_PH_W 2
`define PMSCC_PH_OFF 2'h0
`define PMSCC_PH_PRE 2'h1
`define PMSCC_PH_FAST 2'h2
`define PMSCC_PH_CV 2'h3
`define PMSCC_PULSE_W 3
`define PMSCC_PULSE_FOUR 3'h4
`endif

// [pmscc_deglitch.v]
`timescale 1ns/1ps
`include "pmscc_defines.vh"
// output follows input only after it has held for LIMIT cycles
module pmscc_deglitch #(
	parameter [`PMSCC_CNT_W-1:0] LIMIT = 22'h000001
) (
	// clock and reset
	input wire i_sys_clk,
	input wire i_reset,
	// raw and filtered level
	input wire i_level,
	output reg o_level
);
	reg [`PMSCC_CNT_W-1:0] count;
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			count <= {`PMSCC_CNT_W{1'b0}};
			o_level <= 1'b0;
		end else if (i_level == o_level) begin
			count <= {`PMSCC_CNT_W{1'b0}};
		end else if (count >= LIMIT - 22'h000001) begin
			o_level <= i_level;
			count <= {`PMSCC_CNT_W{1'b0}};
		end else begin
			count <= count + 22'h000001;
		end
	end
endmodule

// [pmscc_host.sv]
`timescale 1ns/1ps
module pmscc_host (
	// clock
	input wire i_sys_clk,
	// enable/programming line
	output logic o_line
);
	// high from start keeps the part off until enabled
	initial o_line = 1'b1;
	task automatic hold(input logic lvl, input int cyc);
		o_line = lvl;
		repeat (cyc) @(negedge i_sys_clk);
	endtask
	// gap equals the width, so both stay inside the valid window
	task automatic pulses(input int n, input int w);
		repeat (n) begin
			hold(1'b1, w);
			hold(1'b0, w);
		end
	endtask
endmodule

// [pmscc_timer.v]
`timescale 1ns/1ps
`include "pmscc_defines.vh"
// counts cycles a level has held since it last changed; saturates
module pmscc_timer (
	// clock and reset
	input wire i_sys_clk,
	input wire i_reset,
	// watched level
	input wire i_level,
	// held-time count and level
	output reg [`PMSCC_CNT_W-1:0] o_count,
	output reg o_level
);
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_count <= {`PMSCC_CNT_W{1'b0}};
			o_level <= 1'b0;
		end else if (i_level != o_level) begin
			o_level <= i_level;
			o_count <= {`PMSCC_CNT_W{1'b0}};
		end else if (o_count != {`PMSCC_CNT_W{1'b1}}) begin
			o_count <= o_count + {{(`PMSCC_CNT_W-1){1'b0}}, 1'b1};
		end
	end
endmodule

// [test_pulse_mode_select_charge_ctrl.sv]
`timescale 1ns/1ps
`include "pmscc_defines.vh"
module test_pulse_mode_select_charge_ctrl;
	localparam int WC = 3200;
	localparam int DC = 1500;
	localparam int OC = 20;
	logic i_sys_clk = 1'b0;
	logic i_reset = 1'b1;
	wire i_enable_line;
	logic i_above_undervoltage_lockout = 1'b1;
	logic i_above_ovp = 1'b0;
	logic i_above_battery_80mv = 1'b1;
	logic i_below_recharge_threshold = 1'b0;
	logic i_above_precharge_exit_threshold = 1'b0;
	logic i_at_battery_regulation_voltage = 1'b0;
	logic i_below_done_threshold = 1'b0;
	logic i_resistor_below_default_limit = 1'b0;
	wire o_charge_switch_on, o_ldo_on, o_precharge_current, o_limit_to_resistor;
	wire o_limit_low, o_voltage_regulation, o_production_test_mode;
	wire o_thermal_regulation_on, o_quiescent_reduced, o_charge_done_n;
	wire o_charge_done_n_oe, o_source_valid_n, o_source_valid_n_oe;
	wire [`PMSCC_MODE_W-1:0] o_mode;
	wire [`PMSCC_PH_W-1:0] o_phase;
	int error_cnt = 0;
	int compares = 0;
	always #5 i_sys_clk = ~i_sys_clk;
	pmscc_host host (.i_sys_clk(i_sys_clk), .o_line(i_enable_line));
	// shortened timing counts; pulse window 100..700 stays inside the decode time
	pmscc_charge_ctrl #(.WAIT_CYC(22'h000c80), .DECODE_CYC(22'h0005dc),
		.OVP_CYC(22'h000014), .DEGLITCH_CYC(22'h00000a),
		.PULSE_MIN_CYC(22'h000064), .PULSE_MAX_CYC(22'h0002bc)) dut (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_enable_line(i_enable_line),
		.i_above_undervoltage_lockout(i_above_undervoltage_lockout),
		.i_above_ovp(i_above_ovp),
		.i_above_battery_80mv(i_above_battery_80mv),
		.i_below_recharge_threshold(i_below_recharge_threshold),
		.i_above_precharge_exit_threshold(i_above_precharge_exit_threshold),
		.i_at_battery_regulation_voltage(i_at_battery_regulation_voltage),
		.i_below_done_threshold(i_below_done_threshold),
		.i_resistor_below_default_limit(i_resistor_below_default_limit),
		.o_charge_switch_on(o_charge_switch_on),
		.o_ldo_on(o_ldo_on),
		.o_precharge_current(o_precharge_current),
		.o_limit_to_resistor(o_limit_to_resistor),
		.o_limit_low(o_limit_low),
		.o_voltage_regulation(o_voltage_regulation),
		.o_production_test_mode(o_production_test_mode),
		.o_thermal_regulation_on(o_thermal_regulation_on),
		.o_quiescent_reduced(o_quiescent_reduced),
		.o_mode(o_mode),
		.o_phase(o_phase),
		.o_charge_done_n(o_charge_done_n),
		.o_charge_done_n_oe(o_charge_done_n_oe),
		.o_source_valid_n(o_source_valid_n),
		.o_source_valid_n_oe(o_source_valid_n_oe)
	);
	////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_modes;
		logic [1:0] exp [5] = '{`PMSCC_MODE_DEFAULT, `PMSCC_MODE_RESISTOR,
			`PMSCC_MODE_LOW, `PMSCC_MODE_TEST, `PMSCC_MODE_LOW};
		// downward so the no-pulse case follows a different mode
		for (int n = 4; n >= 0; n--) begin
			host.hold(1'b1, DC + 100);
			check("quiet", o_quiescent_reduced, 4'h1);
			check("sw dis", o_charge_switch_on, 4'h0);
			host.hold(1'b0, 30);
			host.pulses(n, 300);
			if (n == 4)
				check("mode4", o_mode, 4'h2);
			host.hold(1'b0, (n == 0) ? WC + 100 : DC);
			check("mode", o_mode, {2'h0, exp[n]});
			check("low lim", o_limit_low, {3'h0, exp[n] == `PMSCC_MODE_LOW});
			// test mode entered with no load drawn, well inside the duty limit
			if (n == 3) begin
				check("ptm", o_production_test_mode, 4'h1);
				check("thermal", o_thermal_regulation_on, 4'h0);
			end
			if (n == 0) begin
				check("def lim", o_limit_to_resistor, 4'h0);
				i_resistor_below_default_limit = 1'b1;
				cyc(2);
				check("def res", o_limit_to_resistor, 4'h1);
				i_resistor_below_default_limit = 1'b0;
			end
		end
		$display("modes done");
	endtask
	task automatic t_ignore;
		host.hold(1'b1, DC + 100);
		host.hold(1'b0, 30);
		host.hold(1'b1, 50);
		host.hold(1'b0, 300);
		host.pulses(1, 300);
		host.hold(1'b0, DC);
		check("short", o_mode, 4'h1);
		host.pulses(2, 300);
		host.hold(1'b0, DC);
		check("again", o_mode, 4'h1);
		$display("ignore done");
	endtask
	task automatic t_charge;
		check("idle", o_phase, 4'h0);
		// each phase lasts a span timed here by the host, not by the part
		i_below_recharge_threshold = 1'b1;
		cyc(10);
		check("pre", o_phase, 4'h1);
		check("pre i", o_precharge_current, 4'h1);
		check("chg", o_charge_done_n_oe, 4'h1);
		check("pg", o_source_valid_n_oe, 4'h1);
		check("chg pin", o_charge_done_n, 4'h0);
		check("pg pin", o_source_valid_n, 4'h0);
		i_above_precharge_exit_threshold = 1'b1;
		cyc(10);
		check("fast", o_phase, 4'h2);
		check("res", o_limit_to_resistor, 4'h1);
		i_at_battery_regulation_voltage = 1'b1;
		cyc(10);
		check("cv", o_phase, 4'h3);
		check("cv loop", o_voltage_regulation, 4'h1);
		// threshold taken as set inside its legal span of the fast charge current
		i_below_done_threshold = 1'b1;
		cyc(10);
		check("done", o_charge_done_n_oe, 4'h0);
		check("sw on", o_charge_switch_on, 4'h1);
		i_below_done_threshold = 1'b0;
		i_at_battery_regulation_voltage = 1'b0;
		cyc(10);
		check("refresh", o_charge_done_n_oe, 4'h0);
		i_above_battery_80mv = 1'b0;
		cyc(10);
		check("pg off", o_source_valid_n_oe, 4'h0);
		check("sw pg", o_charge_switch_on, 4'h0);
		i_above_battery_80mv = 1'b1;
		cyc(10);
		$display("charge done");
	endtask
	task automatic t_faults;
		i_above_ovp = 1'b1;
		cyc(OC - 5);
		i_above_ovp = 1'b0;
		cyc(5);
		check("ldo glitch", o_ldo_on, 4'h1);
		i_above_ovp = 1'b1;
		cyc(OC + 10);
		check("ldo ovp", o_ldo_on, 4'h0);
		check("sw ovp", o_charge_switch_on, 4'h0);
		i_above_ovp = 1'b0;
		cyc(10);
		check("ldo back", o_ldo_on, 4'h1);
		i_above_undervoltage_lockout = 1'b0;
		cyc(10);
		check("uv sw", o_charge_switch_on, 4'h0);
		check("uv chg", o_charge_done_n_oe, 4'h0);
		check("uv pg", o_source_valid_n_oe, 4'h0);
		$display("faults done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(negedge i_sys_clk);
		i_reset = 1'b0;
		t_modes;
		t_ignore;
		t_charge;
		t_faults;
		give_verdict;
	end
	initial begin
		#600000;
		error_cnt++;
		$display("FAIL watchdog expired");
		give_verdict;
	end
endmodule
